// ### rtl/tap_pkg.sv
// shared constants and types for the boundary-scan test access port
package tap_pkg;

	// ------------------------------------------------------------------
	// register widths
	// ------------------------------------------------------------------
	localparam int IR_W    = 8;
	localparam int BSR_W   = 52;
	localparam int BCR_W   = 3;
	localparam int ID_W    = 32;
	localparam int SENSE_W = 48;
	localparam int OE_LO   = 48;
	localparam int OE_HI   = 51;

	// ------------------------------------------------------------------
	// reset and capture values
	// ------------------------------------------------------------------
	localparam logic [IR_W-1:0]  IR_CAPTURE = 8'h81;
	localparam logic [IR_W-1:0]  IR_RESET   = 8'h81;
	localparam logic [BCR_W-1:0] BCR_RESET  = 3'h2;
	localparam logic [3:0]       OE_RESET   = 4'h0;
	// arbitrary neutral identification value, lsb kept at one
	localparam logic [ID_W-1:0]  ID_CODE    = 32'h0000_0001;

	// ------------------------------------------------------------------
	// instruction opcodes (bit 7 is even parity over the opcode)
	// ------------------------------------------------------------------
	localparam logic [IR_W-1:0] INS_EXTEST = 8'h00;
	localparam logic [IR_W-1:0] INS_IDCODE = 8'h81;
	localparam logic [IR_W-1:0] INS_SAMPLE = 8'h82;
	localparam logic [IR_W-1:0] INS_RUNT   = 8'h09;
	localparam logic [IR_W-1:0] INS_BCR    = 8'h8E;

	// ------------------------------------------------------------------
	// boundary-control operations
	// ------------------------------------------------------------------
	localparam logic [BCR_W-1:0] OP_PARALLEL_SIGNATURE_ANALYSIS = 3'h2;
	localparam logic [BCR_W-1:0] OP_TOGGLE = 3'h3;
	localparam logic [BCR_W-1:0] OP_COUNT  = 3'h5;

	// gray along capture/shift/exit/pause/update; all 16 codes in use
	typedef enum logic [3:0] {
		ST_RESET    = 4'h0,
		ST_IDLE     = 4'h1,
		ST_SEL_DR   = 4'h3,
		ST_CAP_DR   = 4'h2,
		ST_SHIFT_DR = 4'h6,
		ST_EX1_DR   = 4'h7,
		ST_PAUSE_DR = 4'h5,
		ST_EX2_DR   = 4'h4,
		ST_UPD_DR   = 4'hC,
		ST_SEL_IR   = 4'hD,
		ST_CAP_IR   = 4'hF,
		ST_SHIFT_IR = 4'hE,
		ST_EX1_IR   = 4'hA,
		ST_PAUSE_IR = 4'hB,
		ST_EX2_IR   = 4'h9,
		ST_UPD_IR   = 4'h8
	} tap_state_t;

	typedef enum logic [1:0] {
		SEL_BYPASS = 2'h0,
		SEL_ID     = 2'h1,
		SEL_BSR    = 2'h2,
		SEL_BCR    = 2'h3
	} dr_sel_t;

	typedef struct packed {
		logic             test_mode;
		logic             run_idle;
		logic [BCR_W-1:0] op;
		logic [BSR_W-1:0] bsr;
	} test_view_t;

	localparam int VIEW_W = $bits(test_view_t);

endpackage

// ### rtl/word_handshake_sync.sv
// toggle-handshake crossing of a multi-bit word between two clocks
`timescale 1ns/1ps
module word_handshake_sync #(
	parameter int W = 8
) (
	input  wire logic         src_clk,
	input  wire logic         dst_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] src_word,
	output logic      [W-1:0] dst_word
);

	logic [W-1:0] hold;
	logic         req;
	logic         ack_meta;
	logic         ack_sync;
	logic         req_meta;
	logic         req_sync;
	logic         ack;

	// ------------------------------------------------------------------
	// source side
	// ------------------------------------------------------------------
	// hold only moves once the far side has taken the last word
	always_ff @(posedge src_clk or negedge rst_b) begin
		if (!rst_b) begin
			hold <= '0;
			req  <= 1'b0;
		end else if (ack_sync == req) begin
			hold <= src_word;
			req  <= ~req;
		end
	end

	always_ff @(posedge src_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
		end else begin
			ack_meta <= ack;
			ack_sync <= ack_meta;
		end
	end

	// ------------------------------------------------------------------
	// destination side
	// ------------------------------------------------------------------
	always_ff @(posedge dst_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
		end else begin
			req_meta <= req;
			req_sync <= req_meta;
		end
	end

	always_ff @(posedge dst_clk or negedge rst_b) begin
		if (!rst_b) begin
			dst_word <= '0;
			ack      <= 1'b0;
		end else if (req_sync != ack) begin
			dst_word <= hold;
			ack      <= req_sync;
		end
	end

endmodule

// ### rtl/boundary_scan_tap.sv
// boundary-scan test access port: controller, test registers, core view
`timescale 1ns/1ps
module boundary_scan_tap
	import tap_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	input  wire logic               tck,
	input  wire logic               tms,
	input  wire logic               tdi,
	input  wire logic [SENSE_W-1:0] sense_pins,
	output logic                    tdo,
	output logic                    tdo_oe_b,
	output test_view_t              view
);

	// ------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------
	function automatic logic parity_ok(input logic [IR_W-1:0] ins);
		parity_ok = ~(^ins);
	endfunction

	function automatic dr_sel_t decode_sel(input logic [IR_W-1:0] ins);
		dr_sel_t s;
		s = SEL_BYPASS;
		if (parity_ok(ins)) begin
			unique case (ins)
				INS_IDCODE: s = SEL_ID;
				INS_EXTEST: s = SEL_BSR;
				INS_SAMPLE: s = SEL_BSR;
				INS_RUNT:   s = SEL_BSR;
				INS_BCR:    s = SEL_BCR;
				default:    s = SEL_BYPASS;
			endcase
		end
		decode_sel = s;
	endfunction

	function automatic logic decode_test(input logic [IR_W-1:0] ins);
		decode_test = parity_ok(ins)
			&& (ins == INS_EXTEST || ins == INS_RUNT);
	endfunction

	function automatic logic [SENSE_W-1:0] parallel_signature_analysis(
		input logic [SENSE_W-1:0] s,
		input logic [SENSE_W-1:0] d
	);
		logic fb;
		fb       = s[SENSE_W-1] ^ s[SENSE_W-2] ^ s[20] ^ s[19];
		parallel_signature_analysis = {s[SENSE_W-2:0], fb} ^ d;
	endfunction

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	tap_state_t         state;
	tap_state_t         next_state;
	logic [SENSE_W-1:0] sense_meta;
	logic [SENSE_W-1:0] sense_sync;
	logic [IR_W-1:0]    ir_shift;
	logic [IR_W-1:0]    ir_active;
	logic               bypass_sr;
	logic [ID_W-1:0]    id_sr;
	logic [BSR_W-1:0]   bsr_sr;
	logic [BSR_W-1:0]   bsr_latch;
	logic [BCR_W-1:0]   bcr_sr;
	logic [BCR_W-1:0]   bcr_latch;
	dr_sel_t            dr_sel;
	logic               test_mode;
	logic               dr_lsb;
	test_view_t         view_src;

	assign dr_sel    = decode_sel(ir_active);
	assign test_mode = decode_test(ir_active);

	// ------------------------------------------------------------------
	// controller next state
	// ------------------------------------------------------------------
	// update states go back to select or idle, never straight to a scan
	always_comb begin
		next_state = state;
		unique case (state)
			ST_RESET:    next_state = tms ? ST_RESET : ST_IDLE;
			ST_IDLE:     next_state = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:   next_state = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   next_state = tms ? ST_EX1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: next_state = tms ? ST_EX1_DR : ST_SHIFT_DR;
			ST_EX1_DR:   next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: next_state = tms ? ST_EX2_DR : ST_PAUSE_DR;
			ST_EX2_DR:   next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR:   next_state = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR:   next_state = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR:   next_state = tms ? ST_EX1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: next_state = tms ? ST_EX1_IR : ST_SHIFT_IR;
			ST_EX1_IR:   next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: next_state = tms ? ST_EX2_IR : ST_PAUSE_IR;
			ST_EX2_IR:   next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR:   next_state = tms ? ST_SEL_DR : ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// controller state register
	// ------------------------------------------------------------------
	// six states loop on themselves, the other ten never do
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// pin sense synchroniser
	// ------------------------------------------------------------------
	// pins are unrelated to the test clock
	// capture and signature analysis read only the second stage
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			sense_meta <= '0;
			sense_sync <= '0;
		end else begin
			sense_meta <= sense_pins;
			sense_sync <= sense_meta;
		end
	end

	// ------------------------------------------------------------------
	// instruction shift stage (rising edge)
	// ------------------------------------------------------------------
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			ir_shift <= IR_CAPTURE;
		end else begin
			unique case (state)
				ST_CAP_IR:   ir_shift <= IR_CAPTURE;
				ST_SHIFT_IR: ir_shift <= {tdi, ir_shift[IR_W-1:1]};
				default:     ir_shift <= ir_shift;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// instruction latch (falling edge)
	// ------------------------------------------------------------------
	// a bad-parity opcode still latches and then decodes as bypass
	always_ff @(negedge tck or negedge rst_b) begin
		if (!rst_b) begin
			ir_active <= IR_RESET;
		end else if (state == ST_RESET) begin
			ir_active <= IR_RESET;
		end else if (state == ST_UPD_IR) begin
			ir_active <= ir_shift;
		end
	end

	// ------------------------------------------------------------------
	// data shift stages (rising edge)
	// ------------------------------------------------------------------
	// only the selected register captures or shifts
	// bypass captures zero, so a broken chain shows as a stuck line
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			bypass_sr <= 1'b0;
		end else if (dr_sel == SEL_BYPASS) begin
			if (state == ST_CAP_DR) begin
				bypass_sr <= 1'b0;
			end else if (state == ST_SHIFT_DR) begin
				bypass_sr <= tdi;
			end
		end
	end

	// ------------------------------------------------------------------
	// identification shift stage
	// ------------------------------------------------------------------
	// no shadow latch: capture always reloads the fixed code
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			id_sr <= ID_CODE;
		end else if (dr_sel == SEL_ID) begin
			if (state == ST_CAP_DR) begin
				id_sr <= ID_CODE;
			end else if (state == ST_SHIFT_DR) begin
				id_sr <= {tdi, id_sr[ID_W-1:1]};
			end
		end
	end

	// ------------------------------------------------------------------
	// boundary shift stage
	// ------------------------------------------------------------------
	// scan order runs from the serial input through 51 down to 0
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			bsr_sr <= '0;
		end else if (dr_sel == SEL_BSR) begin
			if (state == ST_CAP_DR) begin
				bsr_sr <= {bsr_latch[OE_HI:OE_LO], sense_sync};
			end else if (state == ST_SHIFT_DR) begin
				bsr_sr <= {tdi, bsr_sr[BSR_W-1:1]};
			end
		end
	end

	// ------------------------------------------------------------------
	// boundary-control shift stage
	// ------------------------------------------------------------------
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			bcr_sr <= BCR_RESET;
		end else if (dr_sel == SEL_BCR) begin
			if (state == ST_CAP_DR) begin
				bcr_sr <= bcr_latch;
			end else if (state == ST_SHIFT_DR) begin
				bcr_sr <= {tdi, bcr_sr[BCR_W-1:1]};
			end
		end
	end

	// ------------------------------------------------------------------
	// shadow latches (falling edge)
	// ------------------------------------------------------------------
	always_ff @(negedge tck or negedge rst_b) begin
		if (!rst_b) begin
			bcr_latch <= BCR_RESET;
		end else if (state == ST_RESET) begin
			bcr_latch <= BCR_RESET;
		end else if (state == ST_UPD_DR && dr_sel == SEL_BCR) begin
			bcr_latch <= bcr_sr;
		end
	end

	// ------------------------------------------------------------------
	// boundary latch and test operations
	// ------------------------------------------------------------------
	// cells below 48 keep whatever they hold through the reset state; rst_b clears them
	always_ff @(negedge tck or negedge rst_b) begin
		if (!rst_b) begin
			bsr_latch <= '0;
		end else if (state == ST_RESET) begin
			bsr_latch[OE_HI:OE_LO] <= OE_RESET;
		end else if (state == ST_UPD_DR && dr_sel == SEL_BSR) begin
			bsr_latch <= bsr_sr;
		end else if (state == ST_IDLE && test_mode) begin
			unique case (bcr_latch)
				OP_PARALLEL_SIGNATURE_ANALYSIS: begin
					bsr_latch[SENSE_W-1:0] <=
						parallel_signature_analysis(
							bsr_latch[SENSE_W-1:0], sense_sync);
				end
				OP_TOGGLE: begin
					bsr_latch[SENSE_W-1:0] <= ~bsr_latch[SENSE_W-1:0];
				end
				OP_COUNT: begin
					bsr_latch[SENSE_W-1:0] <=
						bsr_latch[SENSE_W-1:0] + 48'h0000_0000_0001;
				end
				// other codes run nothing; the cells hold
				default: begin
					bsr_latch <= bsr_latch;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// serial output (falling edge)
	// ------------------------------------------------------------------
	always_comb begin
		unique case (dr_sel)
			SEL_BYPASS: dr_lsb = bypass_sr;
			SEL_ID:     dr_lsb = id_sr[0];
			SEL_BSR:    dr_lsb = bsr_sr[0];
			SEL_BCR:    dr_lsb = bcr_sr[0];
		endcase
	end

	// driving in the falling half keeps data stable for the rising sample
	// a deselected output reads low rather than floating
	always_ff @(negedge tck or negedge rst_b) begin
		if (!rst_b) begin
			tdo      <= 1'b0;
			tdo_oe_b <= 1'b1;
		end else if (state == ST_SHIFT_IR) begin
			tdo      <= ir_shift[0];
			tdo_oe_b <= 1'b0;
		end else if (state == ST_SHIFT_DR) begin
			tdo      <= dr_lsb;
			tdo_oe_b <= 1'b0;
		end else begin
			tdo      <= 1'b0;
			tdo_oe_b <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// core-side view
	// ------------------------------------------------------------------
	// only refreshed while the test clock runs
	// the handshake keeps the struct coherent but may skip values
	assign view_src = '{
		test_mode: test_mode && state != ST_RESET,
		run_idle:  state == ST_IDLE,
		op:        bcr_latch,
		bsr:       bsr_latch
	};

	word_handshake_sync #(
		.W (VIEW_W)
	) u_view_sync (
		.src_clk  (tck),
		.dst_clk  (core_clk),
		.rst_b    (rst_b),
		.src_word (view_src),
		.dst_word (view)
	);

endmodule

// ### bench/scan_ctrl_model.sv
// scan controller model driving the test clock, mode select and data in
`timescale 1ns/1ps
module scan_ctrl_model (
	output logic tck,
	output logic tms,
	output logic tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe_b
);
	logic last;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		last = 1'b0;
	end

	// ------------------------------------------------------------------
	// one test-clock cycle; the clock stands low between calls
	// ------------------------------------------------------------------
	task automatic cyc(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#32;
		// released output has no pull: read it as the inverse of last
		q = tdo_oe_b ? ~last : tdo;
		last = q;
		tck = 1'b1;
		#32;
		tck = 1'b0;
	endtask

	task automatic hold(input logic m, input int n);
		logic b;
		repeat (n) cyc(m, 1'b1, b);
	endtask

	// five high cycles, then one low to settle in idle
	task automatic to_idle();
		hold(1'b1, 5);
		hold(1'b0, 1);
	endtask

	// ------------------------------------------------------------------
	// full scan from idle back to idle, lsb first
	// ------------------------------------------------------------------
	task automatic scan(input logic ir, input int n,
			input logic [63:0] din, output logic [63:0] q);
		logic b;
		q = 64'h0;
		hold(1'b1, ir ? 2 : 1);
		hold(1'b0, 2);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, din[i], b);
			q[i] = b;
		end
		hold(1'b1, 1);
		hold(1'b0, 1);
	endtask
endmodule

// ### bench/tap_chk.sv
// pin-level assertions for the boundary-scan access port
`timescale 1ns/1ps
module tap_chk
	import tap_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               rst_b,
	input wire logic               tck,
	input wire logic               tms,
	input wire logic               tdi,
	input wire logic [SENSE_W-1:0] sense_pins,
	input wire logic               tdo,
	input wire logic               tdo_oe_b,
	input wire test_view_t         view
);
	tap_state_t st;
	logic       tdo_pos;
	logic       oe_pos;
	logic       id_sel;
	logic [3:0] tlr_cnt;

	// ------------------------------------------------------------------
	// shadow of the controller, so pins can be tied to states
	// ------------------------------------------------------------------
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			st <= ST_RESET;
		end else begin
			case (st)
			ST_RESET:    st <= tms ? ST_RESET : ST_IDLE;
			ST_IDLE:     st <= tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:   st <= tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   st <= tms ? ST_EX1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: st <= tms ? ST_EX1_DR : ST_SHIFT_DR;
			ST_EX1_DR:   st <= tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: st <= tms ? ST_EX2_DR : ST_PAUSE_DR;
			ST_EX2_DR:   st <= tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_SEL_IR:   st <= tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR:   st <= tms ? ST_EX1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: st <= tms ? ST_EX1_IR : ST_SHIFT_IR;
			ST_EX1_IR:   st <= tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: st <= tms ? ST_EX2_IR : ST_PAUSE_IR;
			ST_EX2_IR:   st <= tms ? ST_UPD_IR : ST_SHIFT_IR;
			default:     st <= tms ? ST_SEL_DR : ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			tlr_cnt <= 4'h0;
			id_sel <= 1'b1;
			tdo_pos <= 1'b0;
			oe_pos <= 1'b1;
		end else begin
			tlr_cnt <= (st != ST_RESET) ? 4'h0 : tlr_cnt + (tlr_cnt != 4'hF);
			id_sel <= (st == ST_RESET) | (id_sel & (st != ST_UPD_IR));
			tdo_pos <= tdo;
			oe_pos <= tdo_oe_b;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_tdo_fall_only: assert property (
		@(negedge tck) disable iff (!rst_b)
		tdo == tdo_pos && tdo_oe_b == oe_pos)
		else $error("serial output moved on a rising test clock");
	a_tdo_quiet_low: assert property (
		@(posedge tck) disable iff (!rst_b)
		tdo_oe_b |-> !tdo)
		else $error("serial output not low while off");
	a_shift_drives: assert property (
		@(posedge tck) disable iff (!rst_b)
		st inside {ST_SHIFT_DR, ST_SHIFT_IR} |-> !tdo_oe_b)
		else $error("serial output not enabled in shift");
	a_one_reg_path: assert property (
		@(posedge tck) disable iff (!rst_b)
		!(st inside {ST_SHIFT_DR, ST_SHIFT_IR}) |-> tdo_oe_b)
		else $error("serial output enabled outside shift");
	// worst case lands in reset on the fifth edge, seen on the sixth
	a_five_high: assert property (
		@(posedge tck) disable iff (!rst_b)
		tms [*5] |=> st == ST_RESET && tdo_oe_b)
		else $error("five high mode cycles did not reach reset");
	a_ir_cap_lsb: assert property (
		@(posedge tck) disable iff (!rst_b)
		st == ST_SHIFT_IR && $past(st) == ST_CAP_IR
		|-> tdo ##1 (tms || !tdo))
		else $error("instruction capture pattern wrong");
	a_id_after_tlr: assert property (
		@(posedge tck) disable iff (!rst_b)
		id_sel && st == ST_SHIFT_DR && $past(st) == ST_CAP_DR
		|-> tdo == ID_CODE[0])
		else $error("reset instruction did not select identification");
	a_view_tlr: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		tlr_cnt == 4'hF |-> !view.test_mode && !view.run_idle)
		else $error("test mode seen in reset state");
	a_oe_cells_rst: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!$past(rst_b) |-> view.bsr[OE_HI:OE_LO] == OE_RESET)
		else $error("enable cells not cleared by reset");
	a_oe_cells_tlr: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		tlr_cnt == 4'hF |-> view.bsr[OE_HI:OE_LO] == OE_RESET)
		else $error("enable cells not cleared in reset state");

	c_shift_ir: cover property (@(posedge tck) st == ST_SHIFT_IR);
	c_shift_dr: cover property (@(posedge tck) st == ST_SHIFT_DR);
	c_view_tlr: cover property (@(posedge core_clk) tlr_cnt == 4'hF);
endmodule

bind boundary_scan_tap tap_chk tap_chk_inst (
	.core_clk   (core_clk),
	.rst_b      (rst_b),
	.tck        (tck),
	.tms        (tms),
	.tdi        (tdi),
	.sense_pins (sense_pins),
	.tdo        (tdo),
	.tdo_oe_b   (tdo_oe_b),
	.view       (view)
);

// ### bench/tb_top.sv
// self-checking bench for the boundary-scan access port
`timescale 1ns/1ps
module tb_top;
	import tap_pkg::*;

	`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
		num_errors++; \
		$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

	logic               core_clk = 1'b0;
	logic               rst_b = 1'b0;
	logic               tck;
	logic               tms;
	logic               tdi;
	logic [SENSE_W-1:0] sense_pins = 48'hC3A5_0F96_1E2D;
	logic               tdo;
	logic               tdo_oe_b;
	test_view_t         view;
	logic [63:0]        q;
	int                 num_errors = 0;
	int                 samples_checked = 0;

	initial forever #25 core_clk = ~core_clk;

	boundary_scan_tap boundary_scan_tap_inst (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.tck        (tck),
		.tms        (tms),
		.tdi        (tdi),
		.sense_pins (sense_pins),
		.tdo        (tdo),
		.tdo_oe_b   (tdo_oe_b),
		.view       (view)
	);

	scan_ctrl_model scan_ctrl_model_inst (
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi),
		.tdo      (tdo),
		.tdo_oe_b (tdo_oe_b)
	);

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic ld_ir(input logic [7:0] op);
		scan_ctrl_model_inst.scan(1'b1, 8, 64'(op), q);
	endtask

	task automatic t_ir_path();
		scan_ctrl_model_inst.to_idle();
		scan_ctrl_model_inst.scan(1'b1, 16, {48'h0, INS_IDCODE, 8'h5A}, q);
		`CHK(q[7:0], IR_CAPTURE)
		`CHK(q[15:8], 8'h5A)
	endtask

	task automatic t_id_tlr();
		ld_ir(INS_SAMPLE);
		scan_ctrl_model_inst.to_idle();
		scan_ctrl_model_inst.scan(1'b0, 40, 64'hA5, q);
		`CHK(q[31:0], ID_CODE)
		`CHK(q[39:32], 8'hA5)
	endtask

	// unlisted and bad-parity opcodes alike fall back to bypass
	task automatic t_bypass();
		logic [7:0] ops [3] = '{8'h03, 8'h01, 8'hFF};
		foreach (ops[k]) begin
			ld_ir(ops[k]);
			scan_ctrl_model_inst.scan(1'b0, 16, 64'h6CB7, q);
			`CHK(q[0], 1'b0)
			`CHK(q[15:1], 15'h6CB7)
		end
	endtask

	// update leaves ones in the enable cells, so a later reset must clear
	task automatic t_bsr();
		ld_ir(INS_SAMPLE);
		scan_ctrl_model_inst.scan(1'b0, 60, 64'h0F00_0000_0000_003C, q);
		`CHK(q[47:0], sense_pins)
		`CHK(q[51:48], OE_RESET)
		`CHK(q[59:52], 8'h3C)
	endtask

	task automatic t_bcr();
		scan_ctrl_model_inst.to_idle();
		ld_ir(INS_BCR);
		scan_ctrl_model_inst.scan(1'b0, 11, {53'h0, OP_COUNT, 8'hC3}, q);
		`CHK(q[2:0], BCR_RESET)
		`CHK(q[10:3], 8'hC3)
		scan_ctrl_model_inst.hold(1'b0, 12);
		`CHK(view.op, OP_COUNT)
		`CHK(view.run_idle, 1'b1)
	endtask

	task automatic t_mode();
		ld_ir(INS_EXTEST);
		scan_ctrl_model_inst.hold(1'b0, 12);
		`CHK(view.test_mode, 1'b1)
		scan_ctrl_model_inst.hold(1'b1, 20);
		`CHK(view.test_mode, 1'b0)
		`CHK(view.run_idle, 1'b0)
		`CHK(view.bsr[OE_HI:OE_LO], OE_RESET)
		// count: one falling edge after update, then twelve held in idle
		`CHK(view.bsr[SENSE_W-1:0], 48'h0000_0000_000D)
		scan_ctrl_model_inst.to_idle();
		ld_ir(INS_RUNT);
		scan_ctrl_model_inst.hold(1'b0, 12);
		`CHK(view.test_mode, 1'b1)
		`CHK(view.op, BCR_RESET)
	endtask

	// ------------------------------------------------------------------
	// run control
	// ------------------------------------------------------------------
	task automatic end_sim();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#300_000;
		num_errors++;
		end_sim();
	end

	initial begin
		fork
			scan_ctrl_model_inst.hold(1'b1, 4);
			repeat (16) @(negedge core_clk);
		join
		rst_b = 1'b1;
		t_ir_path();
		t_id_tlr();
		t_bypass();
		t_bsr();
		t_bcr();
		t_mode();
		end_sim();
	end
endmodule
